// ==== exp_bus_pkg.sv ====
// Package with command codes, window fields and timing constants for the expansion bus block.
package exp_bus_pkg;
  localparam logic [3:0] CMD_IO_READ   = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam int         BOOT_CLAIM_BIT = 7;
  localparam int         MEM_BASE_LSB   = 8;
  localparam int         MEM_BASE_MSB   = 15;
  localparam int         MEM_ADDR_LSB   = 24;
  localparam int         MEM_ADDR_MSB   = 31;
  localparam int         IO_ADDR_LSB    = 16;
  localparam int         IO_ADDR_MSB    = 31;
  localparam logic [15:0] MEM_BASE_RESET = 16'h0080;
  localparam logic [15:0] IO_BASE_RESET  = 16'h0000;
  localparam logic [4:0]  BURST_STROBES  = 5'h10;
  localparam logic [4:0]  SINGLE_STROBES = 5'h01;
  localparam logic [4:0]  WORD_STROBES   = 5'h04;
  localparam int          PIN_COUNT      = 37;
endpackage : exp_bus_pkg

// ==== exp_bus_ctrl.sv ====
// Expansion bus controller that claims decoded PCI cycles and drives shared pins.
`timescale 1ns/1ps
module exp_bus_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        exp_enable,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] pci_ad_in,
  input  wire logic [3:0]  pci_byte_enable_pins_in,
  input  wire logic        code_burst,
  input  wire logic        io_wide,
  input  wire logic        mem_base_we,
  input  wire logic [15:0] mem_base_wdata,
  input  wire logic        io_base_we,
  input  wire logic [15:0] io_base_wdata,
  input  wire logic [31:0] wr_data,
  output logic [31:0]      pci_ad_out,
  output logic             pci_ad_oe,
  output logic [3:0]       pci_byte_enable_pins_out,
  output logic             pci_byte_enable_pins_oe,
  output logic             devsel_n,
  output logic             trdy_n,
  output logic             pci_int_d_pin,
  output logic [31:0]      rd_data,
  output logic             rd_valid,
  output logic [15:0]      mem_window_base,
  output logic [15:0]      io_window_base
);
  import exp_bus_pkg::*;

  typedef enum logic [1:0] {IDLE, ADDR, STROBE, DONE} state_type;

  state_type   state_q, state_d;
  logic [15:0] mem_base_q, io_base_q;
  logic [23:0] addr_q;
  logic [3:0]  cmd_q;
  logic [4:0]  left_q;
  logic        strobe_q;
  logic [31:0] data_q, rd_q;
  logic        rdv_q;
  logic        wide_q;

  // Decode of the address phase; the boot bit forces a claim of everything.
  wire logic addr_phase = (state_q == IDLE) && !frame_n && exp_enable;
  wire logic [3:0] cmd_in = pci_byte_enable_pins_in;
  wire logic is_mem = (cmd_in == CMD_MEM_READ) || (cmd_in == CMD_MEM_WRITE);
  wire logic is_io  = (cmd_in == CMD_IO_READ) || (cmd_in == CMD_IO_WRITE);
  wire logic boot   = mem_base_q[BOOT_CLAIM_BIT];
  wire logic mem_hit = is_mem && (pci_ad_in[MEM_ADDR_MSB:MEM_ADDR_LSB]
                       == mem_base_q[MEM_BASE_MSB:MEM_BASE_LSB]);
  wire logic io_hit  = is_io && (pci_ad_in[IO_ADDR_MSB:IO_ADDR_LSB] == io_base_q);
  wire logic claim   = addr_phase && (boot || mem_hit || io_hit);
  wire logic cmd_io    = !cmd_q[2];
  wire logic cmd_write = cmd_q[0];

  // Only memory reads repeat; writes and IO accesses are one strobe each. Bursts are kept
  // to code reads so that a stray burst request can never multiply a write.
  wire logic word_read  = (cmd_in == CMD_MEM_READ);
  wire logic burst_read = word_read && code_burst;
  wire logic [4:0] count_init = !word_read ? SINGLE_STROBES :
                                (code_burst ? BURST_STROBES : WORD_STROBES);

  // Next state: each strobe pulse is one cycle low, one high, until the count runs out.
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE:    if (claim) state_d = ADDR;
      ADDR:    if (!irdy_n) state_d = STROBE;
      STROBE:  if (strobe_q && left_q == SINGLE_STROBES) state_d = DONE;
      DONE:    state_d = IDLE;
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Window settings; the boot-claim bit comes up set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_base_q <= MEM_BASE_RESET;
      io_base_q  <= IO_BASE_RESET;
    end else begin
      if (mem_base_we) mem_base_q <= mem_base_wdata;
      if (io_base_we)  io_base_q  <= io_base_wdata;
    end
  end

  // Captured command, address and strobe sequencing; the address advances per byte.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q   <= 24'h000000;
      cmd_q    <= 4'h0;
      left_q   <= 5'h00;
      strobe_q <= 1'b0;
      data_q   <= 32'h00000000;
      wide_q   <= 1'b0;
    end else if (claim) begin
      addr_q   <= pci_ad_in[23:0];
      cmd_q    <= cmd_in;
      left_q   <= count_init;
      strobe_q <= 1'b0;
      wide_q   <= io_wide;
    end else if (state_q == ADDR) begin
      data_q   <= wr_data;
    end else if (state_q == STROBE) begin
      strobe_q <= !strobe_q;
      if (strobe_q) begin
        left_q <= left_q - SINGLE_STROBES;
        addr_q <= addr_q + 24'h000001;
      end
    end
  end

  // Read bytes are collected on the rising edge of each strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q  <= 32'h00000000;
      rdv_q <= 1'b0;
    end else begin
      rdv_q <= (state_q == DONE) && !cmd_write;
      if (state_q == STROBE && !strobe_q && !cmd_write) begin
        // A byte-wide IO read leaves the top lane undefined, so it is not passed on.
        rd_q <= cmd_io ? {16'h0000, (wide_q ? pci_ad_in[31:24] : 8'h00), pci_ad_in[7:0]}
                       : {pci_ad_in[7:0], rd_q[31:8]};
      end
    end
  end

  // Pin drive: selects sit on the enable lanes, strobes only while the global select is low.
  wire logic active   = (state_q == STROBE);
  wire logic strobe_on = active && !strobe_q;
  assign pci_int_d_pin = !(active || state_q == ADDR);
  assign pci_byte_enable_pins_oe = active || state_q == ADDR;
  assign pci_byte_enable_pins_out = {
    !cmd_io,
    cmd_io,
    !(strobe_on && cmd_write),
    !(strobe_on && !cmd_write)};
  assign pci_ad_oe  = pci_byte_enable_pins_oe;
  assign pci_ad_out = {
    cmd_io ? data_q[15:8] : addr_q[23:16],
    addr_q[15:0],
    cmd_io ? data_q[7:0] : data_q[7:0]};
  assign devsel_n  = !(state_q != IDLE);
  assign trdy_n    = !(state_q == DONE);
  assign rd_data   = rd_q;
  assign rd_valid  = rdv_q;
  assign mem_window_base = mem_base_q;
  assign io_window_base  = io_base_q;

  // Assertions.
  sequence strobe_pulse_s;
    !pci_byte_enable_pins_out[0] ##1 pci_byte_enable_pins_out[0];
  endsequence

  chk_boot_after_reset: assert property (@(posedge clk)
    $rose(rst_n) |-> mem_window_base[BOOT_CLAIM_BIT])
    else $error("boot claim not set after reset");
  chk_no_claim_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == IDLE && !claim) |=> pci_int_d_pin)
    else $error("global select low without claim");
  chk_claim_devsel: assert property (@(posedge clk) disable iff (!rst_n)
    claim |=> !devsel_n)
    else $error("claimed cycle lacks device select");
  chk_strobe_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !pci_byte_enable_pins_out[0] |-> !pci_int_d_pin)
    else $error("read strobe outside global select");
  chk_write_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !pci_byte_enable_pins_out[1] |-> (!pci_int_d_pin && cmd_write))
    else $error("write strobe outside write command");
  chk_select_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    active |-> (pci_byte_enable_pins_out[3] != pci_byte_enable_pins_out[2]))
    else $error("device selects not exclusive");
  chk_burst_count: assert property (@(posedge clk) disable iff (!rst_n)
    (claim && code_burst && !cmd_in[0]) |-> ##[2:60] (left_q == SINGLE_STROBES && strobe_q))
    else $error("burst strobe count wrong");
  chk_pulse_shape: assert property (@(posedge clk) disable iff (!rst_n)
    (active && !strobe_q && !cmd_write) |-> strobe_pulse_s)
    else $error("read strobe not one cycle");
  chk_addr_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    active |-> (pci_ad_out[23:8] == addr_q[15:0]))
    else $error("middle lanes not address");

  // Checker helper: read strobe pulses of the current command and whether it was a burst.
  // Counting the pulses here, rather than trusting left_q, catches a miscounted load.
  logic [4:0] pulse_cnt_q;
  logic       burst_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_cnt_q <= 5'h00;
      burst_q     <= 1'b0;
    end else if (claim) begin
      pulse_cnt_q <= 5'h00;
      burst_q     <= burst_read;
    end else if (strobe_on && !cmd_write) begin
      pulse_cnt_q <= pulse_cnt_q + SINGLE_STROBES;
    end
  end

  chk_burst_total: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DONE && burst_q) |-> (pulse_cnt_q == BURST_STROBES))
    else $error("burst did not give sixteen read strobes");
  chk_word_count: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DONE && !burst_q && cmd_q == CMD_MEM_READ) |-> (pulse_cnt_q == WORD_STROBES))
    else $error("word read strobe count wrong");
  chk_select_space: assert property (@(posedge clk) disable iff (!rst_n)
    (claim && (is_mem || is_io)) |=> (pci_byte_enable_pins_out[2] == !$past(is_mem))
      && (pci_byte_enable_pins_out[3] == $past(is_mem)))
    else $error("device select does not match command space");
  chk_addr_capture: assert property (@(posedge clk) disable iff (!rst_n)
    claim |=> (pci_ad_out[23:8] == $past(pci_ad_in[15:0])))
    else $error("middle lanes do not carry claimed address");
endmodule : exp_bus_ctrl

// ==== exp_dev.sv ====
// Model of the memory and IO devices hanging on the expansion pins.
`timescale 1ns/1ps
module exp_dev (
  input  wire logic [31:0] ad_out,
  input  wire logic [3:0]  be_out,
  input  wire logic        glb_n,
  output logic [31:0]      dev_ad,
  output logic             dev_oe
);
  // Selects are gated by the global select, so PCI traffic never wakes a device.
  wire rd_n = be_out[0] | glb_n;
  wire mem_rd = ~(be_out[2] | glb_n) & ~rd_n;
  wire io_rd = ~(be_out[3] | glb_n) & ~rd_n;
  // Read data is derived from the address so every byte position is distinct.
  assign dev_oe = mem_rd | io_rd;
  assign dev_ad = io_rd ? {ad_out[23:16] ^ 8'hC3, 16'h0, ad_out[15:8] ^ 8'h5A}
                        : {24'h0, ad_out[15:8] ^ 8'h5A};
endmodule : exp_dev

// ==== exp_bus_ctrl_tb.sv ====
// Self-checking bench for the expansion bus controller with a device model.
`timescale 1ns/1ps
module exp_bus_ctrl_tb;
  import exp_bus_pkg::*;
  logic clk = 0, rst_n = 0, en = 1, frame_n = 1, irdy_n = 1, burst = 0, mwe = 0, iwe = 0;
  logic [31:0] tb_ad = 0, wdat = 0, ad_out, rd_data, dev_ad, seen;
  logic [15:0] mwd = 0, iwd = 0, mbase, ibase;
  logic [3:0]  be_in = 4'hF, be_out;
  logic        ad_oe, be_oe, devsel_n, trdy_n, glb_n, rd_valid, dev_oe;
  logic        wide = 0;
  int          errors = 0, checks_done = 0, nstb;
  // A released bus shows the testbench pattern instead of stale device data.
  wire  [31:0] ad_in = dev_oe ? dev_ad : tb_ad;
  exp_bus_ctrl exp_bus_ctrl_inst (.clk(clk), .rst_n(rst_n), .exp_enable(en),
    .frame_n(frame_n), .irdy_n(irdy_n), .pci_ad_in(ad_in), .pci_byte_enable_pins_in(be_in),
    .code_burst(burst), .io_wide(wide), .mem_base_we(mwe), .mem_base_wdata(mwd),
    .io_base_we(iwe), .io_base_wdata(iwd), .wr_data(wdat), .pci_ad_out(ad_out),
    .pci_ad_oe(ad_oe), .pci_byte_enable_pins_out(be_out), .pci_byte_enable_pins_oe(be_oe),
    .devsel_n(devsel_n), .trdy_n(trdy_n), .pci_int_d_pin(glb_n), .rd_data(rd_data),
    .rd_valid(rd_valid), .mem_window_base(mbase), .io_window_base(ibase));
  // The global select reaches only the device model, never a bus master.
  exp_dev exp_dev_inst (.ad_out(ad_out), .be_out(be_out), .glb_n(glb_n),
    .dev_ad(dev_ad), .dev_oe(dev_oe));
  // Free-running 40 MHz clock.
  initial forever #12.5 clk = ~clk;
  task automatic results;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // One claimed transfer; counts strobe pulses on lane sb and checks select lane sel.
  task automatic xfer(logic [31:0] ad, logic [3:0] cmd, int sb, int sel);
    int n;
    nstb = 0;
    tb_ad = ad;
    be_in = cmd;
    frame_n = 0;
    @(posedge clk) #2;
    cmp("devsel", 0, devsel_n);
    tb_ad = ~ad;
    be_in = 4'h0;
    irdy_n = 0;
    for (n = 0; n < 200 && trdy_n !== 1'b0; n++) begin
      @(posedge clk) #2;
      if (glb_n === 1'b0 && be_out[sb] === 1'b0) begin
        nstb++;
        seen = ad_out;
        cmp("select", 0, be_out[sel]);
        cmp("drive enables", 3, {ad_oe, be_oe});
      end
    end
    if (n == 200) begin
      errors++;
      results();
    end
    frame_n = 1;
    irdy_n = 1;
    // Read data is announced for one cycle, right after the target-ready cycle.
    @(posedge clk) #2;
    cmp("read valid", !cmd[0], rd_valid);
    @(posedge clk) #2;
    cmp("global idle", 1, glb_n);
    cmp("pins released", 3'b001, {ad_oe, be_oe, devsel_n});
  endtask : xfer
  task automatic t_boot;
    cmp("mem base", 32'h80, mbase);
    cmp("io base", 0, ibase);
    xfer(32'h5500_0010, CMD_MEM_READ, 0, 2);
    cmp("word strobes", WORD_STROBES, nstb);
    cmp("last addr", 32'h13, seen[31:8]);
    cmp("word", 32'h4948_4B4A, rd_data);
  endtask : t_boot
  // Software clears the boot claim while loading both windows.
  task automatic t_miss;
    mwd = 16'h1200;
    iwd = 16'hABCD;
    mwe = 1;
    iwe = 1;
    @(posedge clk) #2;
    {mwe, iwe} = 2'b00;
    tb_ad = 32'h5500_0010;
    be_in = CMD_MEM_READ;
    frame_n = 0;
    repeat (6) @(posedge clk) #2;
    cmp("unclaimed", 2'b11, {devsel_n, glb_n});
    frame_n = 1;
    @(posedge clk) #2;
  endtask : t_miss
  task automatic t_write;
    wdat = 32'h0000_9CE7;
    xfer(32'h1234_5678, CMD_MEM_WRITE, 1, 2);
    cmp("wr strobes", SINGLE_STROBES, nstb);
    cmp("mem lanes", 32'h3456_78E7, seen);
    xfer(32'hABCD_0246, CMD_IO_WRITE, 1, 3);
    cmp("io lanes", 32'h9C02_46E7, seen);
  endtask : t_write
  // Wide and byte IO reads are one strobe each; a code burst keeps the last four bytes.
  task automatic t_io_burst;
    wide = 1;
    xfer(32'hABCD_0246, CMD_IO_READ, 0, 3);
    cmp("io read", 32'hC11C, rd_data[15:0]);
    cmp("io strobes", SINGLE_STROBES, nstb);
    wide = 0;
    xfer(32'hABCD_0246, CMD_IO_READ, 0, 3);
    cmp("io byte read", 32'h001C, rd_data);
    burst = 1;
    xfer(32'h1200_0100, CMD_MEM_READ, 0, 2);
    burst = 0;
    cmp("burst strobes", BURST_STROBES, nstb);
    cmp("burst tail", 32'h5554_5756, rd_data);
  endtask : t_io_burst
  // A second reset in mid-run must bring the boot claim back.
  task automatic t_reset;
    rst_n = 0;
    repeat (2) @(posedge clk) #2;
    cmp("held idle", 3'b111, {devsel_n, trdy_n, glb_n});
    rst_n = 1;
    cmp("boot again", 32'h80, mbase);
    xfer(32'h7700_0004, CMD_MEM_READ, 0, 2);
    cmp("boot word", 32'h5D5C_5F5E, rd_data);
  endtask : t_reset
  // Reset for eight cycles, then run the scenarios in order.
  initial begin
    repeat (8) @(posedge clk);
    #2 rst_n = 1;
    t_boot();
    t_miss();
    t_write();
    t_io_burst();
    t_reset();
    results();
  end
endmodule : exp_bus_ctrl_tb
